/* rtl/cis_defs.svh */
/*
  Constants of the interrupt sequencer: register offsets, field positions,
  reset values and cycle counts.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef CIS_DEFS_SVH
`define CIS_DEFS_SVH

`define CIS_ADDR_W        4
`define CIS_PC_W          13
`define CIS_SP_W          11
`define CIS_NFLAG         8
`define CIS_NLVL          4

`define CIS_OFF_STATUS    4'h0
`define CIS_OFF_CTRL      4'h1
`define CIS_OFF_FLAG      4'h2
`define CIS_OFF_ENA       4'h3
`define CIS_OFF_LVL_ENA   4'h4
`define CIS_OFF_SPL       4'h5
`define CIS_OFF_SPH       4'h6
`define CIS_OFF_LVL_STATE 4'h7

`define CIS_BIT_GIE       7
`define CIS_BIT_RELOC     0

`define CIS_STATUS_RST    8'h00
`define CIS_CTRL_RST      8'h00
`define CIS_SP_RST        11'h000
`define CIS_BOOT_START    13'h1C00
`define CIS_VEC_RESET     5'h00
`define CIS_VEC_FLAG0     5'h01
`define CIS_VEC_LVL0      5'h09
`define CIS_VEC_STEP      13'h0002

`define CIS_ENTRY_CYC     4
`define CIS_WAKE_CYC      4
`define CIS_RET_CYC       4
`define CIS_CNT_LAST      2'h3

`endif

/* rtl/cis_pkg.sv */
/*
  Types of the interrupt sequencer.
  Assumes cis_defs.svh on the include path.
*/
`include "cis_defs.svh"

package cis_pkg;

  typedef struct packed {
    logic insn_done;
    logic sei;
    logic cli;
    logic return_from_handler;
    logic sleeping;
  } cis_core_op_t;

  typedef struct packed {
    logic [`CIS_SP_W-1:0] addr;
    logic [7:0]           wdata;
    logic                 we;
    logic                 re;
  } cis_stack_bus_t;

  typedef struct packed {
    logic [`CIS_ADDR_W-1:0] addr;
    logic [7:0]             wdata;
    logic                   we;
    logic                   re;
  } cis_reg_req_t;

  typedef enum logic [1:0] {
    CIS_ST_RUN    = 2'b00,
    CIS_ST_WAKE   = 2'b01,
    CIS_ST_ENTER  = 2'b10,
    CIS_ST_RETURN = 2'b11
  } cis_state_t;

endpackage : cis_pkg

/* rtl/cis_sequencer.sv */
/*
  Interrupt sequencer of an 8-bit core: flags, enables, priority pick,
  program counter push and pop, vector generation, boot relocation.
  Assumes the core reports instruction boundaries and special opcodes on
  mclk, stalls while core_stall is high, and owns a byte-wide stack memory
  whose read data returns one cycle after stack_bus.re.
*/
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/10ps
`include "cis_defs.svh"

module cis_sequencer (
  input  wire logic                    mclk,
  input  wire logic                    sys_rst,
  input  wire cis_pkg::cis_reg_req_t   reg_req,
  output logic [7:0]                   reg_rdata,
  input  wire cis_pkg::cis_core_op_t   core_op,
  input  wire logic [`CIS_PC_W-1:0]    core_pc,
  input  wire logic [`CIS_NFLAG-1:0]   flag_event,
  input  wire logic [`CIS_NLVL-1:0]    level_cond,
  input  wire logic                    external_request_zero,
  input  wire logic                    boot_reset_fuse,
  input  wire logic                    app_boot_lock_a,
  input  wire logic                    boot_lock_b,
  input  wire logic [7:0]              stack_rdata,
  output cis_pkg::cis_stack_bus_t      stack_bus,
  output logic                         core_stall,
  output logic                         core_wake,
  output logic                         pc_load,
  output logic [`CIS_PC_W-1:0]         pc_value,
  output logic [`CIS_PC_W-1:0]         reset_vector
);
  import cis_pkg::*;

  localparam int NSRC = `CIS_NFLAG + `CIS_NLVL;

  cis_state_t                 state_reg;
  logic [1:0]                 cnt_reg;
  logic [7:0]                 status_reg;
  logic [7:0]                 core_control_reg;
  logic [`CIS_NFLAG-1:0]      flag_reg;
  logic [`CIS_NFLAG-1:0]      ena_reg;
  logic [`CIS_NLVL-1:0]       lvl_ena_reg;
  logic [`CIS_SP_W-1:0]       sp_reg;
  logic [`CIS_PC_W-1:0]       ret_pc_reg;
  logic [4:0]                 vec_reg;
  logic                       hold_reg;
  logic [2:0]                 ext_sync_reg;
  logic [2:0]                 fuse_sync_reg;
  logic [2:0]                 lock_a_sync_reg;
  logic [2:0]                 lock_b_sync_reg;
  logic [`CIS_NLVL-1:0]       lvl_sync1_reg;
  logic [`CIS_NLVL-1:0]       lvl_sync2_reg;

  logic [`CIS_NFLAG-1:0]      flag_set;
  logic [NSRC-1:0]            pending;
  logic                       gie_now;
  logic                       suppress;
  logic                       boundary;
  logic                       accept;
  logic [4:0]                 win_vec;
  logic [NSRC-1:0]            win_onehot;
  logic [`CIS_PC_W-1:0]       table_base;
  logic                       in_boot;

  // Lowest index wins, which is the lowest vector address
  function automatic logic [NSRC-1:0] pick_lowest(input logic [NSRC-1:0] req);
    logic [NSRC-1:0] one;
    logic            found;
    one   = '0;
    found = 1'b0;
    for (int i = 0; i < NSRC; i++)
    begin
      if (req[i] && !found)
      begin
        one[i] = 1'b1;
        found  = 1'b1;
      end
    end
    return one;
  endfunction : pick_lowest

  function automatic logic [4:0] onehot_to_vec(input logic [NSRC-1:0] one);
    logic [4:0] v;
    v = `CIS_VEC_RESET;
    for (int i = 0; i < NSRC; i++)
    begin
      if (one[i])
        v = 5'(`CIS_VEC_FLAG0 + i);
    end
    return v;
  endfunction : onehot_to_vec

  // Pins and fuse lines cross into mclk through a three-flop chain first
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      ext_sync_reg    <= 3'h0;
      fuse_sync_reg   <= 3'h0;
      lock_a_sync_reg <= 3'h0;
      lock_b_sync_reg <= 3'h0;
    end
    else
    begin
      ext_sync_reg    <= {ext_sync_reg[1:0], external_request_zero};
      fuse_sync_reg   <= {fuse_sync_reg[1:0], boot_reset_fuse};
      lock_a_sync_reg <= {lock_a_sync_reg[1:0], app_boot_lock_a};
      lock_b_sync_reg <= {lock_b_sync_reg[1:0], boot_lock_b};
    end
  end

  // Level conditions arrive from outside logic too
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      lvl_sync1_reg <= '0;
      lvl_sync2_reg <= '0;
    end
    else
    begin
      lvl_sync1_reg <= level_cond;
      lvl_sync2_reg <= lvl_sync1_reg;
    end
  end

  always_comb
  begin
    flag_set    = flag_event;
    // Pin zero is edge-flagged on its synchronised rising edge
    flag_set[0] = flag_event[0] | (ext_sync_reg[1] & ~ext_sync_reg[2]);
  end

  // Reset vector follows the fuse, sampled after release
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      reset_vector <= '0;
    else if (fuse_sync_reg[2])
      reset_vector <= `CIS_BOOT_START;
    else
      reset_vector <= '0;
  end

  assign table_base = core_control_reg[`CIS_BIT_RELOC] ? `CIS_BOOT_START
                                                        : '0;
  assign in_boot    = core_pc >= `CIS_BOOT_START;

  // Handlers that live in the other section are kept from preempting locked code
  assign suppress = (lock_a_sync_reg[2] && !in_boot && core_control_reg[`CIS_BIT_RELOC]) ||
                    (lock_b_sync_reg[2] && in_boot && !core_control_reg[`CIS_BIT_RELOC]);

  assign pending = {lvl_sync2_reg & lvl_ena_reg, flag_reg & ena_reg};
  assign gie_now = status_reg[`CIS_BIT_GIE] & ~core_op.cli;
  assign boundary = core_op.insn_done | core_op.sleeping;
  // Sleep alone is no boundary until a program instruction has run after return
  assign accept  = (state_reg == CIS_ST_RUN) && boundary && (core_op.insn_done || !hold_reg) &&
                   !core_op.sei && gie_now && (|pending) && !suppress;
  assign win_onehot = pick_lowest(pending);
  assign win_vec    = onehot_to_vec(win_onehot);

  // Sequencing of entry and return
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      state_reg <= CIS_ST_RUN;
      cnt_reg   <= 2'h0;
      vec_reg   <= `CIS_VEC_RESET;
    end
    else
    begin
      case (state_reg)
        CIS_ST_RUN:
        begin
          cnt_reg <= 2'h0;
          if (accept)
          begin
            vec_reg   <= win_vec;
            state_reg <= core_op.sleeping ? CIS_ST_WAKE : CIS_ST_ENTER;
          end
          else if (core_op.return_from_handler && core_op.insn_done)
            state_reg <= CIS_ST_RETURN;
        end
        CIS_ST_WAKE:
        begin
          cnt_reg <= cnt_reg + 2'h1;
          if (cnt_reg == `CIS_CNT_LAST)
            state_reg <= CIS_ST_ENTER;
        end
        CIS_ST_ENTER, CIS_ST_RETURN:
        begin
          cnt_reg <= cnt_reg + 2'h1;
          if (cnt_reg == `CIS_CNT_LAST)
            state_reg <= CIS_ST_RUN;
        end
        default:
          state_reg <= CIS_ST_RUN;
      endcase
    end
  end

  // Cleared by the first completed program instruction after return
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      hold_reg <= 1'b0;
    else if ((state_reg == CIS_ST_RETURN) && (cnt_reg == `CIS_CNT_LAST))
      hold_reg <= 1'b1;
    else if (state_reg == CIS_ST_RUN && core_op.insn_done)
      hold_reg <= 1'b0;
  end

  // Status: only the enable bit is touched by hardware, nothing is stacked
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      status_reg <= `CIS_STATUS_RST;
    else if (accept)
      status_reg[`CIS_BIT_GIE] <= 1'b0;
    else if ((state_reg == CIS_ST_RETURN) && (cnt_reg == `CIS_CNT_LAST))
      status_reg[`CIS_BIT_GIE] <= 1'b1;
    else if (core_op.cli)
      status_reg[`CIS_BIT_GIE] <= 1'b0;
    else if (core_op.sei)
      status_reg[`CIS_BIT_GIE] <= 1'b1;
    else if (reg_req.we && reg_req.addr == `CIS_OFF_STATUS)
      status_reg <= reg_req.wdata;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      core_control_reg <= `CIS_CTRL_RST;
      ena_reg          <= '0;
      lvl_ena_reg      <= '0;
    end
    else if (reg_req.we)
    begin
      case (reg_req.addr)
        `CIS_OFF_CTRL:    core_control_reg <= reg_req.wdata;
        `CIS_OFF_ENA:     ena_reg          <= reg_req.wdata;
        `CIS_OFF_LVL_ENA: lvl_ena_reg      <= reg_req.wdata[`CIS_NLVL-1:0];
        default:          ;
      endcase
    end
  end

  // Flags: a new event beats any clear in the same cycle
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      flag_reg <= '0;
    else
    begin
      for (int i = 0; i < `CIS_NFLAG; i++)
      begin
        if (flag_set[i])
          flag_reg[i] <= 1'b1;
        else if (accept && win_onehot[i])
          flag_reg[i] <= 1'b0;
        else if (reg_req.we && reg_req.addr == `CIS_OFF_FLAG && reg_req.wdata[i])
          flag_reg[i] <= 1'b0;
      end
    end
  end

  // Stack pointer and captured return address
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      sp_reg     <= `CIS_SP_RST;
      ret_pc_reg <= '0;
    end
    else
    begin
      if (accept)
        ret_pc_reg <= core_pc;
      if ((state_reg == CIS_ST_RETURN) && (cnt_reg == 2'h1))
        ret_pc_reg[7:0] <= stack_rdata;
      if ((state_reg == CIS_ST_RETURN) && (cnt_reg == 2'h2))
        ret_pc_reg[`CIS_PC_W-1:8] <= stack_rdata[`CIS_PC_W-9:0];
      if ((state_reg == CIS_ST_ENTER) && (cnt_reg == 2'h2))
        sp_reg <= sp_reg - 11'h002;
      else if ((state_reg == CIS_ST_RETURN) && (cnt_reg == 2'h2))
        sp_reg <= sp_reg + 11'h002;
      else if (reg_req.we && reg_req.addr == `CIS_OFF_SPL)
        sp_reg[7:0] <= reg_req.wdata;
      else if (reg_req.we && reg_req.addr == `CIS_OFF_SPH)
        sp_reg[`CIS_SP_W-1:8] <= reg_req.wdata[`CIS_SP_W-9:0];
    end
  end

  // Stack port: low byte at sp, high byte at sp-1 on entry
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      stack_bus <= '0;
    else
    begin
      stack_bus.we <= 1'b0;
      stack_bus.re <= 1'b0;
      if (state_reg == CIS_ST_ENTER && cnt_reg == 2'h0)
      begin
        stack_bus.addr  <= sp_reg;
        stack_bus.wdata <= ret_pc_reg[7:0];
        stack_bus.we    <= 1'b1;
      end
      else if (state_reg == CIS_ST_ENTER && cnt_reg == 2'h1)
      begin
        stack_bus.addr  <= sp_reg - 11'h001;
        stack_bus.wdata <= 8'(ret_pc_reg[`CIS_PC_W-1:8]);
        stack_bus.we    <= 1'b1;
      end
      else if (state_reg == CIS_ST_RUN && core_op.return_from_handler && core_op.insn_done && !accept)
      begin
        stack_bus.addr <= sp_reg + 11'h002;
        stack_bus.re   <= 1'b1;
      end
      else if (state_reg == CIS_ST_RETURN && cnt_reg == 2'h0)
      begin
        stack_bus.addr <= sp_reg + 11'h001;
        stack_bus.re   <= 1'b1;
      end
    end
  end

  // Core control: stall through every sequence, load pc at its last cycle
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      core_stall <= 1'b0;
      core_wake  <= 1'b0;
      pc_load    <= 1'b0;
      pc_value   <= '0;
    end
    else
    begin
      core_stall <= accept || (state_reg != CIS_ST_RUN && cnt_reg != `CIS_CNT_LAST) ||
                    (state_reg == CIS_ST_WAKE) ||
                    (state_reg == CIS_ST_RUN && core_op.return_from_handler && core_op.insn_done);
      core_wake  <= accept && core_op.sleeping;
      pc_load    <= 1'b0;
      if (state_reg == CIS_ST_ENTER && cnt_reg == 2'h2)
      begin
        pc_load  <= 1'b1;
        pc_value <= table_base + (13'(vec_reg) * `CIS_VEC_STEP);
      end
      else if (state_reg == CIS_ST_RETURN && cnt_reg == 2'h2)
      begin
        pc_load  <= 1'b1;
        pc_value <= {stack_rdata[`CIS_PC_W-9:0], ret_pc_reg[7:0]};
      end
    end
  end

  // Register reads, unmapped offsets read zero
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      reg_rdata <= 8'h00;
    else if (reg_req.re)
    begin
      case (reg_req.addr)
        `CIS_OFF_STATUS:    reg_rdata <= status_reg;
        `CIS_OFF_CTRL:      reg_rdata <= core_control_reg;
        `CIS_OFF_FLAG:      reg_rdata <= flag_reg;
        `CIS_OFF_ENA:       reg_rdata <= ena_reg;
        `CIS_OFF_LVL_ENA:   reg_rdata <= 8'(lvl_ena_reg);
        `CIS_OFF_SPL:       reg_rdata <= sp_reg[7:0];
        `CIS_OFF_SPH:       reg_rdata <= 8'(sp_reg[`CIS_SP_W-1:8]);
        `CIS_OFF_LVL_STATE: reg_rdata <= 8'(lvl_sync2_reg);
        default:            reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

endmodule : cis_sequencer

/* verif/cis_sequencer_monitor.sv */
/*
  Checker of the interrupt sequencer: stack push/pop shape and timing.
  Assumes binding to cis_sequencer; one clock, synchronous active-high reset.
*/
`timescale 1ns/10ps
`include "cis_defs.svh"

module cis_sequencer_monitor (
  input wire logic                   mclk,
  input wire logic                   sys_rst,
  input wire cis_pkg::cis_reg_req_t  reg_req,
  input wire logic [7:0]             reg_rdata,
  input wire cis_pkg::cis_core_op_t  core_op,
  input wire logic [`CIS_PC_W-1:0]   core_pc,
  input wire logic [`CIS_NFLAG-1:0]  flag_event,
  input wire logic [`CIS_NLVL-1:0]   level_cond,
  input wire logic                   external_request_zero,
  input wire logic                   boot_reset_fuse,
  input wire logic                   app_boot_lock_a,
  input wire logic                   boot_lock_b,
  input wire logic [7:0]             stack_rdata,
  input wire cis_pkg::cis_stack_bus_t stack_bus,
  input wire logic                   core_stall,
  input wire logic                   core_wake,
  input wire logic                   pc_load,
  input wire logic [`CIS_PC_W-1:0]   pc_value,
  input wire logic [`CIS_PC_W-1:0]   reset_vector
);
  import cis_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence seq_push;
    stack_bus.we ##1 stack_bus.we && stack_bus.addr == $past(stack_bus.addr) - 11'h001;
  endsequence
  sequence seq_pop;
    stack_bus.re ##1 stack_bus.re && stack_bus.addr == $past(stack_bus.addr) - 11'h001;
  endsequence

  a_push_pair: assert property ($rose(stack_bus.we) |-> seq_push ##1 !stack_bus.we)
    else $error("entry push is not two bytes downward");
  a_entry_load: assert property ($rose(stack_bus.we) |-> ##2 pc_load)
    else $error("vector load not two cycles after push start");
  a_stall_span: assert property ($rose(stack_bus.we) |-> core_stall[*3] ##1 !core_stall)
    else $error("stall does not end right after vector load");
  a_pop_pair: assert property ($rose(stack_bus.re) |-> seq_pop ##1 !stack_bus.re)
    else $error("return pop is not two bytes");
  a_ret_load: assert property ($rose(stack_bus.re) |-> ##3 pc_load)
    else $error("return load not in fourth cycle");
  a_wake_push: assert property (core_wake |-> ##5 seq_push)
    else $error("wake entry push not four cycles late");
  a_sei_defer: assert property (core_op.sei && core_op.insn_done |-> ##3 !stack_bus.we)
    else $error("interrupt taken on enable instruction");
  a_cli_block: assert property (core_op.cli |-> ##3 !stack_bus.we)
    else $error("interrupt taken with disable instruction");
  a_load_once: assert property (pc_load |=> !pc_load)
    else $error("vector load longer than one cycle");
endmodule : cis_sequencer_monitor

/* verif/cis_stack_mem.sv */
/*
  Partner model: byte-wide stack memory of the core.
  Assumes read data one cycle after a read strobe; otherwise data is junk.
*/
`timescale 1ns/10ps

module cis_stack_mem (
  input wire logic                    mclk,
  input wire cis_pkg::cis_stack_bus_t stack_bus,
  output logic [7:0]                  stack_rdata
);
  import cis_pkg::*;
  logic [7:0] mem [0:2047];

  initial stack_rdata = 8'h00;

  always @(posedge mclk)
  begin
    if (stack_bus.we)
      mem[stack_bus.addr] <= stack_bus.wdata;
    // Toggle outside reads so stale data is never taken for an answer
    if (stack_bus.re)
      stack_rdata <= mem[stack_bus.addr];
    else
      stack_rdata <= ~stack_rdata;
  end
endmodule : cis_stack_mem

/* verif/testbench.sv */
/*
  Directed testbench of the interrupt sequencer with register tasks.
  Assumes cis_stack_mem as stack partner and a 40 MHz clock.
*/
`timescale 1ns/10ps
`include "cis_defs.svh"
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin error_cnt++; \
  $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end

module testbench;
  import cis_pkg::*;
  logic                  mclk;
  logic                  sys_rst;
  cis_reg_req_t          reg_req;
  logic [7:0]            reg_rdata;
  cis_core_op_t          core_op;
  logic [`CIS_PC_W-1:0]  core_pc;
  logic [7:0]            flag_event;
  logic [3:0]            level_cond;
  logic                  boot_reset_fuse;
  logic                  external_request_zero;
  logic                  app_boot_lock_a;
  logic                  boot_lock_b;
  logic [7:0]            stack_rdata;
  cis_stack_bus_t        stack_bus;
  logic                  core_stall;
  logic                  core_wake;
  logic                  pc_load;
  logic [`CIS_PC_W-1:0]  pc_value;
  logic [`CIS_PC_W-1:0]  reset_vector;
  int                    error_cnt;
  int                    samples_checked;
  int                    cyc;
  int                    n;

  cis_sequencer cis_sequencer_i (.mclk(mclk), .sys_rst(sys_rst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .core_op(core_op), .core_pc(core_pc), .flag_event(flag_event),
    .level_cond(level_cond), .external_request_zero(external_request_zero),
    .boot_reset_fuse(boot_reset_fuse), .app_boot_lock_a(app_boot_lock_a),
    .boot_lock_b(boot_lock_b), .stack_rdata(stack_rdata),
    .stack_bus(stack_bus), .core_stall(core_stall), .core_wake(core_wake),
    .pc_load(pc_load), .pc_value(pc_value), .reset_vector(reset_vector));
  cis_stack_mem cis_stack_mem_i (.mclk(mclk), .stack_bus(stack_bus), .stack_rdata(stack_rdata));

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task finish_test;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  always @(posedge mclk)
  begin
    cyc++;
    // Whole run needs well under a thousand cycles
    if (cyc == 4000)
    begin
      error_cnt++;
      finish_test();
    end
  end

  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_req <= '{a, v, 1'b1, 1'b0};
    @(posedge mclk);
    reg_req <= '0;
  endtask : wr

  task rd_chk(input logic [3:0] a, input logic [7:0] e, input string nm);
    @(posedge mclk);
    reg_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge mclk);
    reg_req <= '0;
    #1;
    `CHK(nm, e, reg_rdata)
  endtask : rd_chk

  task op(input logic s, input logic c, input logic r);
    @(posedge mclk);
    core_op <= '{1'b1, s, c, r, 1'b0};
    @(posedge mclk);
    core_op <= '0;
  endtask : op

  task nap;
    @(posedge mclk);
    core_op <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    @(posedge mclk);
    core_op <= '0;
  endtask : nap

  task ev(input int i);
    @(posedge mclk);
    flag_event <= 8'h01 << i;
    @(posedge mclk);
    flag_event <= '0;
  endtask : ev

  task wait_load(input logic [`CIS_PC_W-1:0] e, input int cyc_e, input string nm);
    n = 0;
    while (pc_load !== 1'b1 && n < 20)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    `CHK(nm, e, pc_value)
    `CHK("load_cycles", cyc_e, n)
  endtask : wait_load

  task no_load(input string nm);
    repeat (5)
    begin
      @(posedge mclk);
      #1;
      `CHK(nm, 1'b0, pc_load)
    end
  endtask : no_load

  initial
  begin
    sys_rst = 1'b1;
    reg_req = '0;
    core_op = '0;
    core_pc = 13'h0ABC;
    flag_event = 8'h00;
    level_cond = 4'h0;
    boot_reset_fuse = 1'b0;
    external_request_zero = 1'b0;
    app_boot_lock_a = 1'b0;
    boot_lock_b = 1'b0;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge mclk);
    for (int a = 0; a < 16; a++)
      rd_chk(a[3:0], 8'h00, "reset_value");
    `CHK("reset_vec", 13'h0000, reset_vector)
    wr(4'h5, 8'hFF);
    wr(4'h6, 8'h02);
    $display("test reset done");
    ev(3);
    rd_chk(4'h2, 8'h08, "flag_held");
    wr(4'h2, 8'h00);
    rd_chk(4'h2, 8'h08, "flag_w0");
    wr(4'h2, 8'h08);
    rd_chk(4'h2, 8'h00, "flag_w1");
    $display("test flags done");
    wr(4'h3, 8'h06);
    ev(1);
    ev(2);
    op(1'b1, 1'b0, 1'b0);
    no_load("after_enable");
    op(1'b0, 1'b0, 1'b0);
    // Counted from the accepting edge, itself the first of the entry cycles
    wait_load(13'h0004, `CIS_ENTRY_CYC - 1, "entry_vec");
    rd_chk(4'h2, 8'h04, "flag_auto_clr");
    rd_chk(4'h0, 8'h00, "gie_clear");
    rd_chk(4'h5, 8'hFD, "sp_push");
    `CHK("push_low", 8'hBC, cis_stack_mem_i.mem[11'h2FF])
    `CHK("push_high", 8'h0A, cis_stack_mem_i.mem[11'h2FE])
    $display("test entry done");
    op(1'b0, 1'b0, 1'b1);
    wait_load(13'h0ABC, `CIS_RET_CYC - 1, "return_pc");
    rd_chk(4'h0, 8'h80, "gie_set");
    rd_chk(4'h5, 8'hFF, "sp_pop");
    nap();
    no_load("one_more");
    op(1'b0, 1'b0, 1'b0);
    wait_load(13'h0006, `CIS_ENTRY_CYC - 1, "next_vec");
    op(1'b0, 1'b0, 1'b1);
    wait_load(13'h0ABC, `CIS_RET_CYC - 1, "return_pc2");
    $display("test return done");
    op(1'b0, 1'b0, 1'b0);
    ev(1);
    op(1'b0, 1'b1, 1'b0);
    no_load("disable_same");
    rd_chk(4'h0, 8'h00, "gie_off");
    $display("test disable done");
    wr(4'h1, 8'h01);
    wr(4'h0, 8'h80);
    nap();
    wait_load(13'h1C04, `CIS_ENTRY_CYC - 1 + `CIS_WAKE_CYC, "sleep_reloc");
    wr(4'h1, 8'h00);
    op(1'b0, 1'b0, 1'b1);
    wait_load(13'h0ABC, `CIS_RET_CYC - 1, "return_pc3");
    $display("test sleep done");
    op(1'b0, 1'b0, 1'b0);
    @(posedge mclk);
    level_cond <= 4'h1;
    repeat (5) @(posedge mclk);
    level_cond <= 4'h0;
    repeat (4) @(posedge mclk);
    wr(4'h4, 8'h01);
    op(1'b0, 1'b0, 1'b0);
    no_load("level_gone");
    @(posedge mclk);
    level_cond <= 4'h1;
    repeat (4) @(posedge mclk);
    op(1'b0, 1'b0, 1'b0);
    wait_load(13'h0012, `CIS_ENTRY_CYC - 1, "level_vec");
    @(posedge mclk);
    level_cond <= 4'h0;
    op(1'b0, 1'b0, 1'b1);
    wait_load(13'h0ABC, `CIS_RET_CYC - 1, "return_pc4");
    $display("test level done");
    wr(4'h3, 8'h07);
    external_request_zero <= 1'b1;
    ev(2);
    repeat (4) @(posedge mclk);
    op(1'b0, 1'b0, 1'b0);
    wait_load(13'h0002, `CIS_ENTRY_CYC - 1, "pin_first");
    rd_chk(4'h2, 8'h04, "pin_flag_clr");
    op(1'b0, 1'b0, 1'b1);
    wait_load(13'h0ABC, `CIS_RET_CYC - 1, "return_pc5");
    $display("test pin done");
    @(posedge mclk);
    core_pc <= 13'h1D00;
    boot_lock_b <= 1'b1;
    repeat (4) @(posedge mclk);
    op(1'b0, 1'b0, 1'b0);
    no_load("lock_b_hold");
    wr(4'h1, 8'h01);
    core_pc <= 13'h0ABC;
    app_boot_lock_a <= 1'b1;
    repeat (4) @(posedge mclk);
    op(1'b0, 1'b0, 1'b0);
    no_load("lock_a_hold");
    @(posedge mclk);
    app_boot_lock_a <= 1'b0;
    repeat (4) @(posedge mclk);
    op(1'b0, 1'b0, 1'b0);
    wait_load(13'h1C06, `CIS_ENTRY_CYC - 1, "lock_free");
    $display("test lock done");
    @(posedge mclk);
    boot_reset_fuse <= 1'b1;
    sys_rst <= 1'b1;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    `CHK("boot_reset_vec", 13'h1C00, reset_vector)
    $display("test fuse done");
    finish_test();
  end
endmodule : testbench

bind cis_sequencer cis_sequencer_monitor cis_sequencer_monitor_i (.mclk(mclk), .sys_rst(sys_rst),
  .reg_req(reg_req), .reg_rdata(reg_rdata), .core_op(core_op), .core_pc(core_pc),
  .flag_event(flag_event), .level_cond(level_cond),
  .external_request_zero(external_request_zero), .boot_reset_fuse(boot_reset_fuse),
  .app_boot_lock_a(app_boot_lock_a), .boot_lock_b(boot_lock_b), .stack_rdata(stack_rdata),
  .stack_bus(stack_bus), .core_stall(core_stall), .core_wake(core_wake), .pc_load(pc_load),
  .pc_value(pc_value), .reset_vector(reset_vector));
